// ==== port_pkg.sv ====
// Package with register map, reset values and pin roles for the 8-bit muxed port
package port_pkg;

  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 32;

  // Register byte addresses
  localparam logic [31:0] ADDR_DATA       = 32'hFFFFF052;
  localparam logic [31:0] ADDR_DIRECTION  = 32'hFFFFF056;
  localparam logic [31:0] ADDR_FUNCTION   = 32'hFFFFF05A;
  localparam logic [31:0] ADDR_OPEN_DRAIN = 32'hFFFFF05E;

  // Reset values
  localparam logic [7:0]  RST_LATCH       = 8'hFF;
  localparam logic [7:0]  RST_DIRECTION   = 8'h00;
  localparam logic [7:0]  RST_FUNCTION    = 8'h00;
  localparam logic [7:0]  RST_OPEN_DRAIN  = 8'h00;

  // Writable bits of the open-drain register (0, 1, 3, 4, 6)
  localparam logic [7:0]  OD_WRITABLE     = 8'h5B;

  // Bit positions of the alternate functions
  localparam int          BIT_S2_CLK      = 0;
  localparam int          BIT_S3_TX       = 1;
  localparam int          BIT_S3_RX       = 2;
  localparam int          BIT_S3_CLK      = 3;
  localparam int          BIT_S4_TX       = 4;
  localparam int          BIT_S4_RX       = 5;
  localparam int          BIT_S4_CLK      = 6;
  localparam int          BIT_IRQ         = 7;

  // Value read at an unmapped address
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

endpackage : port_pkg

// ==== port_pin_cell.sv ====
// One pad cell: chooses port or alternate source and applies push-pull or open drain
`timescale 1ns/1ps
`default_nettype none

module port_pin_cell (
  // Configuration
  input  wire logic dir_out,
  input  wire logic func_alt,
  input  wire logic open_drain,
  // Data sources
  input  wire logic latch_val,
  input  wire logic alt_val,
  // Pad side
  output logic      pad_out,
  output logic      pad_oe
);

  logic src;

  // Alternate source only when the function bit is set
  assign src = func_alt ? alt_val : latch_val;

  // Open drain drives low only; a high level is left to the pull-up
  always_comb begin
    pad_out = src;
    pad_oe  = dir_out;
    if (open_drain) begin
      pad_out = 1'b0;
      pad_oe  = dir_out & ~src;
    end
  end

endmodule : port_pin_cell

`default_nettype wire

// ==== port_d_gpio.sv ====
// Top of the 8-bit general port with serial and interrupt alternate functions
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module port_d_gpio (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Register port
  input  wire logic [port_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [port_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic      [port_pkg::DATA_W-1:0]    reg_rdata,
  // Pads
  input  wire logic [port_pkg::DATA_W-1:0]    pad_in,
  output logic      [port_pkg::DATA_W-1:0]    pad_out,
  output logic      [port_pkg::DATA_W-1:0]    pad_oe,
  // Serial channel 2
  input  wire logic                           serial2_clock_out,
  output logic                                serial2_clock_in,
  output logic                                serial2_clear_to_send,
  // Serial channel 3
  input  wire logic                           serial3_transmit,
  output logic                                serial3_receive,
  input  wire logic                           serial3_clock_out,
  output logic                                serial3_clock_in,
  output logic                                serial3_clear_to_send,
  // Serial channel 4
  input  wire logic                           serial4_transmit,
  output logic                                serial4_receive,
  input  wire logic                           serial4_clock_out,
  output logic                                serial4_clock_in,
  output logic                                serial4_clear_to_send,
  // Interrupt controller
  output logic                                external_irq_line
);
  import port_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] latch;
    logic [DATA_W-1:0] direction;
    logic [DATA_W-1:0] function_sel;
    logic [DATA_W-1:0] open_drain;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t            state_reg;
  state_t            state_next;
  logic [DATA_W-1:0] alt_src;
  logic [DATA_W-1:0] data_view;
  logic [DATA_W-1:0] alt_in;
  logic [DATA_W-1:0] alt_listen;

  // Alternate output sources per bit; receive and interrupt pins keep the latch as their source
  always_comb begin
    alt_src             = state_reg.latch;
    alt_src[BIT_S2_CLK] = serial2_clock_out;
    alt_src[BIT_S3_TX]  = serial3_transmit;
    alt_src[BIT_S3_CLK] = serial3_clock_out;
    alt_src[BIT_S4_TX]  = serial4_transmit;
    alt_src[BIT_S4_CLK] = serial4_clock_out;
  end

  // Pad cells; drive follows direction, released by open drain on a high source; function picks the source
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_pin
      port_pin_cell u_cell (
        .dir_out    (state_reg.direction[i]),
        .func_alt   (state_reg.function_sel[i]),
        .open_drain (state_reg.open_drain[i]),
        .latch_val  (state_reg.latch[i]),
        .alt_val    (alt_src[i]),
        .pad_out    (pad_out[i]),
        .pad_oe     (pad_oe[i])
      );
    end
  endgenerate

  // Input route to peripherals: only in alternate mode with direction in
  assign alt_listen = state_reg.function_sel & ~state_reg.direction;
  assign alt_in     = pad_in & alt_listen;

  // Pins not listening rest high, also while the port drives them, so no false clock or CTS
  assign serial2_clock_in      = alt_in[BIT_S2_CLK] | ~alt_listen[BIT_S2_CLK];
  assign serial2_clear_to_send = serial2_clock_in;
  assign serial3_clock_in      = alt_in[BIT_S3_CLK] | ~alt_listen[BIT_S3_CLK];
  assign serial3_clear_to_send = serial3_clock_in;
  assign serial4_clock_in      = alt_in[BIT_S4_CLK] | ~alt_listen[BIT_S4_CLK];
  assign serial4_clear_to_send = serial4_clock_in;
  assign serial3_receive       = alt_in[BIT_S3_RX] | ~alt_listen[BIT_S3_RX];
  assign serial4_receive       = alt_in[BIT_S4_RX] | ~alt_listen[BIT_S4_RX];
  // Interrupt input idles low; wake-from-stop use is software policy
  assign external_irq_line     = alt_in[BIT_IRQ];

  // Read view of data: pin for inputs, latch for outputs
  assign data_view = (pad_in & ~state_reg.direction)
                   | (state_reg.latch & state_reg.direction);

  // Register writes and registered read data
  always_comb begin
    state_next = state_reg;
    if (reg_write) begin
      if (reg_addr == ADDR_DATA) begin
        state_next.latch = reg_wdata;
      end else if (reg_addr == ADDR_DIRECTION) begin
        state_next.direction = reg_wdata;
      end else if (reg_addr == ADDR_FUNCTION) begin
        state_next.function_sel = reg_wdata;
      end else if (reg_addr == ADDR_OPEN_DRAIN) begin
        state_next.open_drain = reg_wdata & OD_WRITABLE;
      end
    end
    // Read data stands only in the cycle after the strobe
    state_next.rdata = READ_UNMAPPED;
    if (reg_read) begin
      if (reg_addr == ADDR_DATA) begin
        state_next.rdata = data_view;
      end else if (reg_addr == ADDR_DIRECTION) begin
        state_next.rdata = state_reg.direction;
      end else if (reg_addr == ADDR_FUNCTION) begin
        state_next.rdata = state_reg.function_sel;
      end else if (reg_addr == ADDR_OPEN_DRAIN) begin
        state_next.rdata = state_reg.open_drain & OD_WRITABLE;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.latch        <= RST_LATCH;
      state_reg.direction    <= RST_DIRECTION;
      state_reg.function_sel <= RST_FUNCTION;
      state_reg.open_drain   <= RST_OPEN_DRAIN;
      state_reg.rdata        <= READ_UNMAPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;

endmodule : port_d_gpio

`default_nettype wire

// ==== port_d_gpio_asserts.sv ====
// Port-level checker for the muxed port
`timescale 1ns/1ps
`default_nettype none
module port_d_gpio_asserts import port_pkg::*; (
  // Clock, reset, register port and pads
  input wire logic        clk, rst_n, reg_write, reg_read,
  input wire logic [31:0] reg_addr,
  input wire logic [7:0]  reg_wdata, reg_rdata, pad_oe, pad_out,
  // Peripheral side
  input wire logic        serial2_clock_in, serial2_clear_to_send, serial3_receive,
  input wire logic        serial3_clock_in, serial3_clear_to_send, serial4_receive,
  input wire logic        serial4_clock_in, serial4_clear_to_send, external_irq_line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rd_at(logic [31:0] a); reg_read && reg_addr == a; endsequence
  sequence wr_dir; reg_write && reg_addr == ADDR_DIRECTION; endsequence
  // Decode helper: reads elsewhere must return the idle value
  logic mapped;
  assign mapped = reg_addr inside {ADDR_DATA, ADDR_DIRECTION, ADDR_FUNCTION, ADDR_OPEN_DRAIN};

  reset_state_a: assert property (!$past(rst_n) |-> pad_oe == RST_DIRECTION && pad_out == RST_LATCH) else $error("state after reset wrong");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside answer cycle");
  unmapped_read_a: assert property (reg_read && !mapped |=> reg_rdata == READ_UNMAPPED) else $error("unmapped read not zero");
  od_read_a: assert property (rd_at(ADDR_OPEN_DRAIN) |=> (reg_rdata & ~OD_WRITABLE) == 8'h00) else $error("fixed open-drain bits set");
  dir_input_a: assert property (wr_dir |=> (pad_oe & ~$past(reg_wdata)) == 8'h00) else $error("input pin driven");
  dir_readback_a: assert property (wr_dir ##1 rd_at(ADDR_DIRECTION) |=> reg_rdata == $past(reg_wdata, 2)) else $error("direction readback wrong");
  irq_input_a: assert property (external_irq_line |-> !pad_oe[7]) else $error("irq from driven pin");
  receive_input_a: assert property ((!serial3_receive |-> !pad_oe[2]) and (!serial4_receive |-> !pad_oe[5])) else $error("receive from driven pin");
  clock_pair_a: assert property (serial2_clock_in == serial2_clear_to_send && serial3_clock_in == serial3_clear_to_send && serial4_clock_in == serial4_clear_to_send) else $error("clock and cts differ");
  clock_input_a: assert property ((!serial2_clock_in |-> !pad_oe[0]) and (!serial3_clock_in |-> !pad_oe[3]) and (!serial4_clock_in |-> !pad_oe[6])) else $error("clock in from driven pin");
endmodule : port_d_gpio_asserts
bind port_d_gpio port_d_gpio_asserts i_chk (.*);
`default_nettype wire

// ==== pin_partner.sv ====
// Far-side pin model: the level each pad really shows
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Pads from the port, and what the outside holds on a released pad
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pad_in
);
  // Driven pad wins; a released one, open drain too, shows the outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pin_partner
`default_nettype wire

// ==== test_eight_bit_port_with_serial_muxing.sv ====
// Self-checking bench for the muxed port
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_port_with_serial_muxing;
  import port_pkg::*;
  localparam logic [7:0] ALT_SRC = 8'h5B;
  logic        clk = 0, rst_n = 0, reg_write = 0, reg_read = 0;
  logic [31:0] reg_addr = '0, lfsr = 32'h829186FF;
  logic [7:0]  reg_wdata = '0, ext = 8'hA5, reg_rdata, pad_in, pad_out, pad_oe;
  logic [7:0]  l, d, f, o, e, s, sr, od, eo, eu, pin, im, v;
  logic [4:0]  sv = '0;
  logic [8:0]  per;
  int          num_errors = 0, total_checks = 0, cyc = 0;
  port_d_gpio i_dut (.*, .serial2_clock_out(sv[0]), .serial2_clock_in(per[8]),
    .serial2_clear_to_send(per[7]), .serial3_transmit(sv[1]), .serial3_receive(per[6]),
    .serial3_clock_out(sv[2]), .serial3_clock_in(per[5]), .serial3_clear_to_send(per[4]),
    .serial4_transmit(sv[3]), .serial4_receive(per[3]), .serial4_clock_out(sv[4]),
    .serial4_clock_in(per[2]), .serial4_clear_to_send(per[1]), .external_irq_line(per[0]));
  pin_partner i_pins (.*, .ext_level(ext));
  function automatic logic [31:0] nxt(logic [31:0] x);
    for (int k = 0; k < 32; k++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction : nxt
  task automatic check(logic [8:0] seen, logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One bus cycle; strobes stay up so back-to-back cycles need no gap
  task automatic op(logic w, logic r, logic [31:0] a, logic [7:0] dd);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= dd;
    @(posedge clk);
    #1;
  endtask : op
  task automatic rd(logic [31:0] a, logic [7:0] x);
    op(1'b0, 1'b1, a, 8'h00);
    check({1'b0, reg_rdata}, {1'b0, x});
  endtask : rd
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  always #25 clk = ~clk;
  // Hang guard, well above the 555 cycles of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    op(1'b0, 1'b0, ADDR_DATA, 8'h00);
    check({1'b0, pad_out}, {1'b0, RST_LATCH});
    rd(ADDR_DIRECTION, 8'h00);
    rd(ADDR_FUNCTION, 8'h00);
    rd(ADDR_OPEN_DRAIN, 8'h00);
    rd(ADDR_DATA, ext);
    // Random settings, the first three forced to all-alternate corners
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      {o, f, d, l} = lfsr;
      lfsr = nxt(lfsr);
      e = lfsr[7:0];
      if (i < 2) {f, d, e} = {8'hFF, 8'h00, {8{i[0]}}};
      if (i == 2) {f, d, o} = 24'hFFFFFF;
      s = {1'b0, lfsr[12], 1'b0, lfsr[11:10], 1'b0, lfsr[9:8]};
      ext <= e;
      sv <= lfsr[12:8];
      op(1'b1, 1'b0, ADDR_DATA, l);
      op(1'b1, 1'b0, ADDR_FUNCTION, f);
      op(1'b1, 1'b0, ADDR_OPEN_DRAIN, o);
      op(1'b1, 1'b0, ADDR_DIRECTION, d);
      rd(ADDR_DIRECTION, d);
      op(1'b1, 1'b0, ADDR_DATA + 32'h1, ~l);
      rd(ADDR_DATA + 32'h1, READ_UNMAPPED);
      rd(ADDR_FUNCTION, f);
      rd(ADDR_OPEN_DRAIN, o & OD_WRITABLE);
      repeat (3) op(1'b0, 1'b0, ADDR_DATA, 8'h00);
      sr = (f & ALT_SRC & s) | (~(f & ALT_SRC) & l);
      od = o & OD_WRITABLE;
      eo = d & ~(od & sr);
      eu = sr & ~od;
      pin = (eo & eu) | (~eo & e);
      im = f & ~d;
      v = (im & pin) | ~im;
      check({1'b0, pad_oe}, {1'b0, eo});
      check({1'b0, pad_out}, {1'b0, eu});
      check(per, {v[0], v[0], v[2], v[3], v[3], v[5], v[6], v[6], im[7] & pin[7]});
      rd(ADDR_DATA, (d & l) | (~d & pin));
    end
    // Mid-run reset with every pin driven and handed over: all fall back to port inputs
    op(1'b1, 1'b0, ADDR_DATA, 8'h00);
    op(1'b1, 1'b0, ADDR_FUNCTION, 8'hFF);
    op(1'b1, 1'b0, ADDR_DIRECTION, 8'hFF);
    rst_n <= 1'b0;
    repeat (3) op(1'b0, 1'b0, ADDR_DATA, 8'h00);
    rst_n <= 1'b1;
    check({1'b0, pad_oe}, 9'h000);
    check({1'b0, pad_out}, {1'b0, RST_LATCH});
    rd(ADDR_FUNCTION, RST_FUNCTION);
    rd(ADDR_DIRECTION, RST_DIRECTION);
    op(1'b1, 1'b0, ADDR_DIRECTION, 8'hFF);
    rd(ADDR_DATA, RST_LATCH);
    test_done();
  end
endmodule : test_eight_bit_port_with_serial_muxing
`default_nettype wire
